//--- core/aea_defines.vh
// Constants for the apparent energy accumulator.
// Assumes word-indexed register port, 24-bit data.
`ifndef AEA_DEFINES_VH
`define AEA_DEFINES_VH
// ****************
// Register offsets
// ****************
`define AEA_A_MODE 8'h00
`define AEA_A_DIV 8'h01
`define AEA_A_EN 8'h02
`define AEA_A_EN_RC 8'h03
`define AEA_A_LINCNT 8'h04
`define AEA_A_LVA 8'h05
`define AEA_A_LWA 8'h06
`define AEA_A_MEASUREMENT_MODE_REG 8'h07
`define AEA_A_GAIN_A 8'h08
`define AEA_A_GAIN_B 8'h09
`define AEA_A_GAIN_C 8'h0A
`define AEA_A_STAT 8'h0B
`define AEA_A_WAVE 8'h0C
`define AEA_A_IEN 8'h0D
`define AEA_A_WMODE 8'h0E
// ****************
// Fields
// ****************
`define AEA_F_FORM_HI 7
`define AEA_F_FORM_LO 6
`define AEA_F_LSEL_HI 5
`define AEA_F_LSEL_LO 3
`define AEA_F_SEL_HI 2
`define AEA_F_SEL_LO 0
`define AEA_F_ZX_HI 6
`define AEA_F_ZX_LO 4
`define AEA_F_REACT 5
`define AEA_F_WSEL_HI 2
`define AEA_F_WSEL_LO 0
`define AEA_F_ST_HALF 0
`define AEA_F_ST_LINE 1
`define AEA_FORM_SUM 2'h0
`define AEA_FORM_AVG 2'h1
`define AEA_FORM_VA 2'h2
// ****************
// Reset values and timing
// ****************
`define AEA_RST_MODE 8'h07
`define AEA_RST_DIV 8'h00
`define AEA_RST_LIN 16'hFFFF
`define AEA_RST_WMODE 8'h07
`define AEA_STEP_CLKS 12
`define AEA_STEP_LAST 4'hB
`define AEA_GAIN_ONE 13'h1000
`endif

//--- core/aea_top.v
// Apparent energy accumulator with line-synchronous energy.
// Assumes RMS, power and zero-crossing inputs come from logic on clock.
//
// Overview of operation
// - Phase select bits include or drop terms
// - Formula field picks sum, mean-voltage, A-voltage
// - Each term scaled by one plus gain/4096
// - 49-bit accumulator, readable upper 24 bits
// - Accumulation step every 12 clocks
// - Accumulation add is signed
// - 8-bit divider, zero acts as one
// - Read-clear energy view clears on read
// - Energy register wraps positive to negative
// - Half-full event, interrupt when enabled
// - Line accumulation always runs over half cycles
// - Zero crossings counted per measurement mode bits 4-6
// - Count bit enables zero-crossing functions
// - 16-bit unsigned half-cycle count
// - Count done sets flag, interrupt when enabled
// - Line energies share identical half cycles
// - Line mode has its own select bits
// - Line energy uses same path and weight
// - Reactive mode puts active energy in LVA, reactive in LWA
// - Active energy in reactive mode unsigned
// - Reactive mode uses WMODE select bits for both line sums
// - Formula field sits at bits 7 to 6
//
// Our own choices: the placing of the registers and the plain strobed port.

`timescale 1ns/1ps
`default_nettype none
`include "aea_defines.vh"

module aea_top (
  input wire clock,
  input wire reset_n,
  input wire [7:0] reg_addr,
  input wire [23:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [23:0] reg_rdata,
  input wire [15:0] vrms_a,
  input wire [15:0] vrms_b,
  input wire [15:0] vrms_c,
  input wire [15:0] irms_a,
  input wire [15:0] irms_b,
  input wire [15:0] irms_c,
  input wire [23:0] act_a,
  input wire [23:0] act_b,
  input wire [23:0] act_c,
  input wire [23:0] react_a,
  input wire [23:0] react_b,
  input wire [23:0] react_c,
  input wire zx_a,
  input wire zx_b,
  input wire zx_c,
  output reg [2:0] zx_enable,
  output reg irq_n
);

  // ****************
  // Registers
  // ****************
  reg [7:0] mode_q;
  reg [7:0] div_q;
  reg [15:0] lin_q;
  reg [7:0] measurement_mode_reg_q;
  reg [11:0] gain_a_q;
  reg [11:0] gain_b_q;
  reg [11:0] gain_c_q;
  reg [7:0] wave_q;
  reg [1:0] ien_q;
  reg [1:0] stat_q;
  reg [7:0] wmode_q;

  reg [3:0] step_cnt_q;
  reg step_q;

  reg [48:0] acc_q;
  reg [48:0] rc_acc_q;
  reg [48:0] la_run_q;
  reg [48:0] lw_run_q;

  reg [23:0] lva_q;
  reg [23:0] lwa_q;
  reg [15:0] hc_q;
  reg [23:0] en_prev_q;

  // ****************
  // Arithmetic helpers
  // ****************
  // One phase term with gain correction
  function [34:0] term;
    input [15:0] v;
    input [15:0] i;
    input [11:0] g;
    input en;
    reg [31:0] p;
    reg [12:0] k;
    reg [44:0] s;
    begin
      p = v * i;
      k = `AEA_GAIN_ONE + {g[11], g};
      s = p * k;
      term = en ? {2'b00, s[44:12]} : 35'h0;
    end
  endfunction

  // Total apparent power for a given term select
  function [34:0] power;
    input [1:0] form;
    input [2:0] sel;
    reg [16:0] vsum;
    reg [15:0] vb;
    begin
      vsum = {1'b0, vrms_a} + {1'b0, vrms_c};
      case (form)
        `AEA_FORM_SUM: vb = vrms_b;
        `AEA_FORM_AVG: vb = vsum[16:1];
        `AEA_FORM_VA: vb = vrms_a;
        default: vb = 16'h0000;
      endcase
      power = term(vrms_a, irms_a, gain_a_q, sel[0])
        + term(vb, irms_b, gain_b_q, sel[1])
        + term(vrms_c, irms_c, gain_c_q, sel[2]);
    end
  endfunction

  // Signed sum of selected per-phase samples
  function [25:0] psum;
    input [2:0] sel;
    input [23:0] a;
    input [23:0] b;
    input [23:0] c;
    reg [25:0] ea;
    reg [25:0] eb;
    reg [25:0] ec;
    begin
      ea = sel[0] ? {{2{a[23]}}, a} : 26'h0;
      eb = sel[1] ? {{2{b[23]}}, b} : 26'h0;
      ec = sel[2] ? {{2{c[23]}}, c} : 26'h0;
      psum = ea + eb + ec;
    end
  endfunction

  // Divided view, upper 24 bits of 49
  // Limitation: a new divider rescales the view at once
  function [23:0] divview;
    input [48:0] a;
    input [7:0] d;
    reg [48:0] q;
    begin
      q = $signed(a) / $signed({1'b0, (d == 8'h00) ? 8'h01 : d});
      divview = q[48:25];
    end
  endfunction

  // ****************
  // Combinational datapath
  // ****************
  wire react_mode = wave_q[`AEA_F_REACT];
  wire [1:0] form = mode_q[`AEA_F_FORM_HI:`AEA_F_FORM_LO];
  wire [2:0] wsel = wmode_q[`AEA_F_WSEL_HI:`AEA_F_WSEL_LO];
  wire [2:0] lsel = react_mode ? wsel : mode_q[`AEA_F_LSEL_HI:`AEA_F_LSEL_LO];
  wire [34:0] pwr = power(form, mode_q[`AEA_F_SEL_HI:`AEA_F_SEL_LO]);
  wire [34:0] lpwr = power(form, lsel);
  wire [25:0] act_sum = psum(lsel, act_a, act_b, act_c);
  wire [25:0] react_sum = psum(wsel, react_a, react_b, react_c);
  // power is never negative, so it enters
  // the signed sums zero-extended
  wire [48:0] pwr_x = {14'h0, pwr};
  wire [48:0] lpwr_x = {14'h0, lpwr};
  wire [48:0] act_s = {{23{act_sum[25]}}, act_sum};
  wire [48:0] act_u = {23'h0, act_sum};
  wire [48:0] react_s = {{23{react_sum[25]}}, react_sum};
  wire [48:0] la_add = react_mode ? act_u : lpwr_x;
  wire [48:0] lw_add = react_mode ? react_s : act_s;
  wire [23:0] energy = divview(acc_q, div_q);
  wire [23:0] energy_rc = divview(rc_acc_q, div_q);
  wire rc_read = reg_rd && (reg_addr == `AEA_A_EN_RC);

  wire [1:0] zx_n = {1'b0, zx_a & measurement_mode_reg_q[`AEA_F_ZX_LO]}
    + {1'b0, zx_b & measurement_mode_reg_q[`AEA_F_ZX_LO + 1]}
    + {1'b0, zx_c & measurement_mode_reg_q[`AEA_F_ZX_HI]};
  wire [16:0] hc_sum = {1'b0, hc_q} + {15'h0, zx_n};
  wire line_done = (lin_q != 16'h0000) && (hc_sum >= {1'b0, lin_q});

  // Band entry only, so a parked value fires once
  // half-full crossing, either sign
  wire half_evt = (energy[23] ^ energy[22]) && !(en_prev_q[23] ^ en_prev_q[22]);

  // ****************
  // Step divider
  // ****************
  // Free-running, so the step phase never slips
  // step every 12 clocks
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      step_cnt_q <= 4'h0;
      step_q <= 1'b0;
    end else begin
      step_q <= (step_cnt_q == `AEA_STEP_LAST);
      if (step_cnt_q == `AEA_STEP_LAST) begin
        step_cnt_q <= 4'h0;
      end else begin
        step_cnt_q <= step_cnt_q + 4'h1;
      end
    end
  end

  // ****************
  // Energy accumulators
  // ****************
  // reset clears energies
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      acc_q <= 49'h0;
      rc_acc_q <= 49'h0;
      en_prev_q <= 24'h0;
    end else begin
      en_prev_q <= energy;
      if (step_q) begin
        acc_q <= acc_q + pwr_x;
      end
      // read clears, a coinciding step survives
      if (rc_read) begin
        rc_acc_q <= step_q ? pwr_x : 49'h0;
      end else if (step_q) begin
        rc_acc_q <= rc_acc_q + pwr_x;
      end
    end
  end

  // ****************
  // Line-synchronous accumulation
  // ****************
  // A step on the closing edge opens the next window
  // always running
  // both line sums restart on the same crossing
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      la_run_q <= 49'h0;
      lw_run_q <= 49'h0;
      lva_q <= 24'h0;
      lwa_q <= 24'h0;
      hc_q <= 16'h0000;
    end else begin
      if (line_done) begin
        hc_q <= 16'h0000;
        lva_q <= divview(la_run_q, div_q);
        lwa_q <= divview(lw_run_q, div_q);
        la_run_q <= step_q ? la_add : 49'h0;
        lw_run_q <= step_q ? lw_add : 49'h0;
      end else begin
        hc_q <= hc_sum[15:0];
        if (step_q) begin
          la_run_q <= la_run_q + la_add;
          lw_run_q <= lw_run_q + lw_add;
        end
      end
    end
  end

  // ****************
  // Register port
  // ****************
  // Read-only and unmapped offsets ignore writes
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mode_q <= `AEA_RST_MODE;
      div_q <= `AEA_RST_DIV;
      lin_q <= `AEA_RST_LIN;
      measurement_mode_reg_q <= 8'h00;
      gain_a_q <= 12'h000;
      gain_b_q <= 12'h000;
      gain_c_q <= 12'h000;
      wave_q <= 8'h00;
      ien_q <= 2'h0;
      wmode_q <= `AEA_RST_WMODE;
    end else if (reg_wr) begin
      case (reg_addr)
        `AEA_A_MODE: mode_q <= reg_wdata[7:0];
        `AEA_A_DIV: div_q <= reg_wdata[7:0];
        `AEA_A_LINCNT: lin_q <= reg_wdata[15:0];
        `AEA_A_MEASUREMENT_MODE_REG: measurement_mode_reg_q <= reg_wdata[7:0];
        `AEA_A_GAIN_A: gain_a_q <= reg_wdata[11:0];
        `AEA_A_GAIN_B: gain_b_q <= reg_wdata[11:0];
        `AEA_A_GAIN_C: gain_c_q <= reg_wdata[11:0];
        `AEA_A_WAVE: wave_q <= reg_wdata[7:0];
        `AEA_A_IEN: ien_q <= reg_wdata[1:0];
        `AEA_A_WMODE: wmode_q <= reg_wdata[7:0];
        default: ;
      endcase
    end
  end

  // Status: write one to clear, a new event wins
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stat_q <= 2'h0;
    end else begin
      if (reg_wr && (reg_addr == `AEA_A_STAT)) begin
        stat_q[`AEA_F_ST_HALF] <= half_evt | (stat_q[0] & ~reg_wdata[0]);
        stat_q[`AEA_F_ST_LINE] <= line_done | (stat_q[1] & ~reg_wdata[1]);
      end else begin
        stat_q[`AEA_F_ST_HALF] <= half_evt | stat_q[0];
        stat_q[`AEA_F_ST_LINE] <= line_done | stat_q[1];
      end
    end
  end

  // ****************
  // Outputs
  // ****************
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irq_n <= 1'b1;
      zx_enable <= 3'h0;
    end else begin
      // Lags status by one flop to stay glitch free
      // line done pulls interrupt low when its enable bit is set
      irq_n <= ~|(stat_q & ien_q);
      zx_enable <= measurement_mode_reg_q[`AEA_F_ZX_HI:`AEA_F_ZX_LO];
    end
  end

  // Unmapped offsets read zero
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 24'h0;
    end else if (reg_rd) begin
      case (reg_addr)
        `AEA_A_MODE: reg_rdata <= {16'h0, mode_q};
        `AEA_A_DIV: reg_rdata <= {16'h0, div_q};
        `AEA_A_EN: reg_rdata <= energy;
        `AEA_A_EN_RC: reg_rdata <= energy_rc;
        `AEA_A_LINCNT: reg_rdata <= {8'h0, lin_q};
        `AEA_A_LVA: reg_rdata <= lva_q;
        `AEA_A_LWA: reg_rdata <= lwa_q;
        `AEA_A_MEASUREMENT_MODE_REG: reg_rdata <= {16'h0, measurement_mode_reg_q};
        `AEA_A_GAIN_A: reg_rdata <= {12'h0, gain_a_q};
        `AEA_A_GAIN_B: reg_rdata <= {12'h0, gain_b_q};
        `AEA_A_GAIN_C: reg_rdata <= {12'h0, gain_c_q};
        `AEA_A_STAT: reg_rdata <= {22'h0, stat_q};
        `AEA_A_WAVE: reg_rdata <= {16'h0, wave_q};
        `AEA_A_IEN: reg_rdata <= {22'h0, ien_q};
        `AEA_A_WMODE: reg_rdata <= {16'h0, wmode_q};
        default: reg_rdata <= 24'h0;
      endcase
    end else begin
      reg_rdata <= 24'h0;
    end
  end

endmodule
`default_nettype wire

//--- verif/aea_sva.sv
// Port checker for the apparent energy accumulator.
// Assumes it is bound to aea_top and sees its ports only.
`timescale 1ns/1ps
`default_nettype none
`include "aea_defines.vh"
module aea_sva (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [23:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [23:0] reg_rdata,
  input wire logic [2:0] zx_enable,
  input wire logic irq_n
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // ****************
  // Sequences
  // ****************
  sequence wr_to(a); reg_wr && reg_addr == a; endsequence
  sequence rd_of(a); reg_rd && reg_addr == a; endsequence
  sequence no_wr(a); !(reg_wr && reg_addr == a); endsequence
  // ****************
  // Assertions
  // ****************
  idle_zero_a: assert property (!reg_rd |=> reg_rdata == 24'h0)
    else $error("read data not zero outside read answer");
  unmapped_a: assert property (reg_rd && reg_addr > 8'h0E |=> reg_rdata == 24'h0)
    else $error("unmapped read returned data");
  reset_out_a: assert property ($rose(reset_n) |-> irq_n && zx_enable == 3'h0)
    else $error("outputs not idle after reset");
  zx_follow_a: assert property (wr_to(`AEA_A_MEASUREMENT_MODE_REG) ##1 no_wr(`AEA_A_MEASUREMENT_MODE_REG) [*2]
    |-> zx_enable == $past(reg_wdata[6:4], 2)) else $error("zero crossing enables wrong");
  irq_off_a: assert property (reg_wr && reg_addr == `AEA_A_IEN && reg_wdata[1:0] == 2'h0
    ##1 no_wr(`AEA_A_IEN) [*3] |-> irq_n) else $error("interrupt active while disabled");
  mode_rt_a: assert property (wr_to(`AEA_A_MODE) ##1 rd_of(`AEA_A_MODE)
    |=> reg_rdata == {16'h0, $past(reg_wdata[7:0], 2)}) else $error("mode readback wrong");
  div_rt_a: assert property (wr_to(`AEA_A_DIV) ##1 rd_of(`AEA_A_DIV)
    |=> reg_rdata == {16'h0, $past(reg_wdata[7:0], 2)}) else $error("divider readback wrong");
  lin_rt_a: assert property (wr_to(`AEA_A_LINCNT) ##1 rd_of(`AEA_A_LINCNT)
    |=> reg_rdata == {8'h0, $past(reg_wdata[15:0], 2)}) else $error("count readback wrong");
endmodule
bind aea_top aea_sva aea_sva_i (.clock, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .zx_enable, .irq_n);
`default_nettype wire

//--- verif/tb_top.sv
// Self-checking bench for the apparent energy accumulator.
// Assumes aea_top and its defines header are on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "aea_defines.vh"
module tb_top;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [23:0] reg_wdata = 24'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] va = 16'h0, vb = 16'h0, vc = 16'h0, ia = 16'h0, ib = 16'h0, ic = 16'h0;
  logic [23:0] pw = 24'h0;
  logic [23:0] pr = 24'h0;
  logic [2:0] zx = 3'h0;
  logic [23:0] q, e0;
  wire [23:0] reg_rdata;
  wire [2:0] zx_enable;
  wire irq_n;
  int failures = 0, cmp_count = 0, cycles = 0;
  // Terms chosen as whole multiples of the readable weight
  localparam logic [7:0] TM [7] = '{8'h02, 8'h42, 8'h82, 8'h01, 8'h01, 8'h01, 8'h00};
  localparam logic [11:0] TG [7] = '{12'h0, 12'h0, 12'h0, 12'h0, 12'h800, 12'h0, 12'h0};
  localparam logic [7:0] TD [7] = '{8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h2, 8'h0};
  localparam logic [23:0] TE [7] = '{24'h2, 24'h6, 24'h8, 24'h4, 24'h2, 24'h2, 24'h0};
  localparam logic [7:0] RA [8] = '{8'h00, 8'h01, 8'h04, 8'h02, 8'h03, 8'h05, 8'h06, 8'hFF};
  localparam logic [23:0] RE [8] = '{24'h7, 24'h0, 24'hFFFF, 24'h0, 24'h0, 24'h0, 24'h0, 24'h0};
  aea_top aea_top_i (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .vrms_a(va), .vrms_b(vb), .vrms_c(vc), .irms_a(ia), .irms_b(ib), .irms_c(ic),
    .act_a(pw), .act_b(pw), .act_c(pw), .react_a(pr), .react_b(pr), .react_c(pr),
    .zx_a(zx[0]), .zx_b(zx[1]), .zx_c(zx[2]), .zx_enable(zx_enable), .irq_n(irq_n));
  always #20 clock = ~clock;
  // ****************
  // Tasks
  // ****************
  task automatic end_sim;
    $display("Counts: %0d compares, %0d failures", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 4000) begin
      failures++;
      end_sim;
    end
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) begin
      @(posedge clock);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      zx <= 3'h0;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    reg_addr <= a;
    reg_wdata <= d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [23:0] r);
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    reg_addr <= a;
    cyc(1);
    @(negedge clock);
    r = reg_rdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [23:0] e);
    rd(a, q);
    chk(q, e);
  endtask
  task automatic zxp(input logic [2:0] m);
    @(posedge clock);
    reg_wr <= 1'b0;
    zx <= m;
    cyc(1);
  endtask
  // Crossings 48 clocks apart, ignored phase B pulse between
  task automatic line_win(input logic [23:0] eva, input logic [23:0] ewa);
    zxp(3'h1);
    wr(`AEA_A_STAT, 24'h3);
    zxp(3'h2);
    cyc(43);
    zxp(3'h1);
    cyc(4);
    rd(`AEA_A_STAT, q);
    chk({23'h0, q[1]}, 24'h1);
    rdc(`AEA_A_LVA, eva);
    rdc(`AEA_A_LWA, ewa);
  endtask
  // ****************
  // Main sequence
  // ****************
  initial begin
    repeat (6) @(posedge clock);
    reset_n <= 1'b1;
    chk({20'h0, irq_n, zx_enable}, 24'h8);
    for (int i = 0; i < 8; i++) rdc(RA[i], RE[i]);
    $display("test reset done");
    @(posedge clock);
    {va, vb, vc} <= {16'h8000, 16'h2000, 16'h4000};
    {ia, ib, ic} <= {16'h0800, 16'h1000, 16'h0800};
    pw <= 24'h400000;
    pr <= 24'hC00000;
    cyc(30);
    rd(`AEA_A_EN, e0);
    cyc(46);
    rd(`AEA_A_EN, q);
    chk(q - e0, 24'h10);
    $display("test energy done");
    for (int i = 0; i < 7; i++) begin
      wr(`AEA_A_MODE, {16'h0, TM[i]});
      rdc(`AEA_A_MODE, {16'h0, TM[i]});
      wr(`AEA_A_GAIN_A, {12'h0, TG[i]});
      wr(`AEA_A_DIV, {16'h0, TD[i]});
      rdc(`AEA_A_DIV, {16'h0, TD[i]});
      cyc(30);
      rd(`AEA_A_EN_RC, q);
      cyc(22);
      rdc(`AEA_A_EN_RC, TE[i]);
    end
    $display("test formula done");
    wr(`AEA_A_MODE, 24'h38);
    wr(`AEA_A_LINCNT, 24'h1);
    rdc(`AEA_A_LINCNT, 24'h1);
    wr(`AEA_A_MEASUREMENT_MODE_REG, 24'h10);
    wr(`AEA_A_IEN, 24'h2);
    cyc(3);
    chk({21'h0, zx_enable}, 24'h1);
    line_win(24'h10, 24'h1);
    chk({23'h0, irq_n}, 24'h0);
    wr(`AEA_A_IEN, 24'h0);
    cyc(4);
    chk({23'h0, irq_n}, 24'h1);
    wr(`AEA_A_MODE, 24'h08);
    wr(`AEA_A_WAVE, 24'h20);
    line_win(24'h1, 24'hFFFFFE);
    $display("test line done");
    @(posedge clock);
    reset_n <= 1'b0;
    cyc(2);
    reset_n <= 1'b1;
    for (int i = 0; i < 8; i++) rdc(RA[i], RE[i]);
    chk({20'h0, irq_n, zx_enable}, 24'h8);
    $display("test mid-run reset done");
    end_sim;
  end
endmodule
`default_nettype wire
